// >>> src/ecp_pkg.sv
package ecp_pkg;
  // ---------------------------------------------------------------
  // register map (offsets within the port's 11-bit window)
  // ---------------------------------------------------------------
  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STATUS = 11'h001;
  localparam logic [10:0] OFS_CONTROL = 11'h002;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_CFG_B = 11'h401;
  localparam logic [10:0] OFS_EXT_CTRL = 11'h402;
  localparam int UPPER_BIT = 10;
  // ---------------------------------------------------------------
  // reset values and constants
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_A_VALUE = 8'h10;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [2:0] EXT_MODE_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int CTL_ACKINT = 4;
  localparam int CTL_DIR = 5;
  // extended control fields
  localparam int ECR_EMPTY = 0;
  localparam int ECR_FULL = 1;
  localparam int ECR_SVC = 2;
  localparam int ECR_DMA = 3;
  localparam int ECR_ERR = 4;
  localparam int ECR_MODE_LO = 5;
  // ---------------------------------------------------------------
  // fifo
  // ---------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam logic [7:0] RLE_CMD_BIT = 8'h80;

  typedef enum logic [2:0] {
    MODE_STD = 3'b000,
    MODE_BIDIR = 3'b001,
    MODE_COMPAT_DATA_FIFO = 3'b010,
    MODE_ECP = 3'b011,
    MODE_EPP = 3'b100,
    MODE_RSVD = 3'b101,
    MODE_TEST = 3'b110,
    MODE_CONFIG = 3'b111
  } ecp_mode_e;

  // fifo entry: tag high marks channel address / rle command
  typedef struct packed {
    logic tag;
    logic [7:0] data;
  } ecp_word_s;

  // link state: one bit changes per step, except FWAIT and RACK back to IDLE
  typedef enum logic [2:0] {
    LS_IDLE = 3'b000,
    LS_FSTB = 3'b001,
    LS_FWAIT = 3'b011,
    LS_RREQ = 3'b010,
    LS_RACK = 3'b110,
    LS_TURN = 3'b100
  } ecp_link_e;
endpackage

// >>> src/ecp_fifo.sv
`timescale 1ns/1ps
module ecp_fifo import ecp_pkg::*; #(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // state
  input wire logic flush_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign count_o = count;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    next_wr_ptr = wr_ptr + AW'(push);
    next_rd_ptr = rd_ptr + AW'(pop);
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage has no reset; content qualified by count
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule // ecp_fifo

// >>> src/ecp_port.sv
`timescale 1ns/1ps
module ecp_port import ecp_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [10:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // dma
  output logic dma_req_o,
  input wire logic dma_ack_i,
  // cable outputs (active low levels as on pins)
  output logic host_clock_line_n_o,
  output logic host_handshake_line_n_o,
  output logic init_line_n_o,
  output logic mode_select_line_n_o,
  // cable data bus
  input wire logic [7:0] pdata_i,
  output logic [7:0] pdata_o,
  output logic pdata_oe_o,
  // cable inputs
  input wire logic periph_clock_line_n_i,
  input wire logic periph_handshake_i,
  input wire logic direction_acknowledge_n_i,
  input wire logic fault_line_n_i,
  input wire logic select_i,
  // irq level for configuration b
  input wire logic irq_level_i,
  output logic error_o
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] port_data, next_port_data;
  logic [5:0] device_control, next_device_control;
  logic [2:0] mode, next_mode;
  logic dma_en, next_dma_en;
  logic svc, next_svc;
  logic err, next_err;
  logic [7:0] last_rd, next_last_rd;
  logic [7:0] rle_cnt, next_rle_cnt;
  logic rle_pend, next_rle_pend;
  ecp_link_e state, next_state;
  ecp_word_s out_word, next_out_word;
  logic rev_dir, next_rev_dir;

  logic sel_fifo, sel_lo, is_ecp, is_compat_data_fifo, dir_in;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, flush;
  ecp_word_s f_in, f_out;
  logic [4:0] f_count;
  logic bus_wr_fifo, bus_rd_fifo, link_push, link_pop;

  assign is_ecp = (mode == MODE_ECP);
  assign is_compat_data_fifo = (mode == MODE_COMPAT_DATA_FIFO);
  // modes 000 and 010 are always output
  assign dir_in = device_control[CTL_DIR] & (mode != MODE_STD) & (mode != MODE_COMPAT_DATA_FIFO);
  assign sel_fifo = addr_i[UPPER_BIT];
  assign sel_lo = ~addr_i[UPPER_BIT];

  // ---------------------------------------------------------------
  // fifo
  // ---------------------------------------------------------------
  // one buffer serves both directions and the test port
  ecp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(f_in),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out),
    .flush_i(flush),
    .count_o(f_count)
  );

  // mode change empties the buffer
  assign flush = wr_i & (addr_i == OFS_EXT_CTRL) & (wdata_i[7:5] != mode);
  // software writes at 400h or address port, dma writes forward
  assign bus_wr_fifo = ((wr_i & sel_fifo & (addr_i == OFS_FIFO)
                         & (is_compat_data_fifo | (is_ecp & ~dir_in) | mode == MODE_TEST))
                        | (wr_i & (addr_i == OFS_DATA) & is_ecp & ~dir_in)
                        | (dma_ack_i & ~dir_in));
  assign bus_rd_fifo = (rd_i & (addr_i == OFS_FIFO) & ((is_ecp & dir_in) | mode == MODE_TEST))
                       | (dma_ack_i & dir_in);
  // one push per reverse byte; byte taken from the latch, bus may already be released
  assign link_push = (state == LS_RACK) & ~periph_clock_line_n_i & ~rle_pend & periph_handshake_i;

  always_comb begin
    f_in_valid = 1'b0;
    f_in = '0;
    if (bus_wr_fifo) begin
      f_in_valid = 1'b1;
      f_in.tag = (addr_i == OFS_DATA) & ~dma_ack_i;
      f_in.data = dma_ack_i ? wdata_i : wdata_i;
    end else if (link_push) begin
      f_in_valid = 1'b1; // reverse data byte
      f_in.data = last_rd;
    end else if (rle_cnt != 8'h00) begin
      f_in_valid = 1'b1; // replay of run
      f_in.data = last_rd;
    end
  end

  // dma paces on fifo state; read side also drains in test mode
  assign dma_req_o = dma_en & (is_ecp | is_compat_data_fifo) & (dir_in ? f_out_valid : f_in_ready);
  assign f_out_ready = bus_rd_fifo | link_pop;
  assign link_pop = (state == LS_FWAIT) & periph_handshake_i & ~dir_in;

  // ---------------------------------------------------------------
  // link engine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_out_word = out_word;
    next_rev_dir = rev_dir;
    next_rle_cnt = rle_cnt;
    next_rle_pend = rle_pend;
    next_last_rd = last_rd;
    if (rle_cnt != 8'h00 && f_in_ready && !bus_wr_fifo && !link_push) begin
      next_rle_cnt = rle_cnt - 8'h01;
    end
    unique case (state)
      LS_IDLE: begin
        if ((is_ecp | is_compat_data_fifo) && !dir_in && rev_dir == 1'b0 && f_out_valid && !periph_handshake_i) begin
          next_state = LS_FSTB;
          next_out_word = f_out;
        end else if (is_ecp && dir_in && !rev_dir) begin
          next_rev_dir = 1'b1;
        end else if (is_ecp && dir_in && !direction_acknowledge_n_i && f_in_ready && rle_cnt == 8'h00) begin
          next_state = LS_RREQ;
        end else if (rev_dir && !dir_in) begin
          next_rev_dir = 1'b0;
          next_state = LS_TURN;
        end
      end
      LS_FSTB: begin
        // strobe held until busy shows the byte taken
        if (periph_handshake_i) begin
          next_state = LS_FWAIT;
        end
      end
      LS_FWAIT: begin
        next_state = LS_IDLE;
      end
      LS_RREQ: begin
        if (!periph_clock_line_n_i) begin
          next_state = LS_RACK;
          if (!periph_handshake_i) begin
            next_rle_pend = 1'b1;
            next_rle_cnt = 8'h00;
            next_last_rd = pdata_i;
          end else if (rle_pend) begin
            next_rle_pend = 1'b0;
            next_last_rd = pdata_i;
            next_rle_cnt = {1'b0, last_rd[6:0]};
          end else begin
            next_last_rd = pdata_i;
          end
        end else if (!dir_in) begin
          // request withdrawn before a byte came, else the turn would hang
          next_state = LS_IDLE;
        end
      end
      LS_RACK: begin
        if (periph_clock_line_n_i) begin
          next_state = LS_IDLE;
        end
      end
      LS_TURN: begin
        // no bus drive until the peripheral goes forward
        if (direction_acknowledge_n_i) begin
          next_state = LS_IDLE;
        end
      end
      default: next_state = LS_IDLE;
    endcase
    if (!(is_ecp | is_compat_data_fifo)) begin
      next_state = LS_IDLE;
      next_rev_dir = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_comb begin
    next_port_data = port_data;
    next_device_control = device_control;
    next_mode = mode;
    next_dma_en = dma_en;
    next_svc = svc;
    next_err = err | (~fault_line_n_i & ~rev_dir & is_ecp);
    if (wr_i && sel_lo && addr_i == OFS_DATA && (mode == MODE_STD || mode == MODE_BIDIR)) begin
      next_port_data = wdata_i;
    end
    if (wr_i && addr_i == OFS_CONTROL) begin
      next_device_control = wdata_i[5:0];
    end
    if (wr_i && addr_i == OFS_EXT_CTRL) begin
      next_mode = wdata_i[7:5];
      next_dma_en = wdata_i[ECR_DMA];
      next_svc = wdata_i[ECR_SVC];
      // set wins over the clear
      next_err = wdata_i[ECR_ERR] & err | (~fault_line_n_i & ~rev_dir & is_ecp);
    end
  end

  always_comb begin
    rdata_o = 8'h00;
    unique case (addr_i)
      OFS_DATA: rdata_o = (mode == MODE_BIDIR && dir_in) ? pdata_i : port_data;
      OFS_STATUS: rdata_o = {~periph_handshake_i, periph_clock_line_n_i, direction_acknowledge_n_i,
                             select_i, fault_line_n_i, 3'h0};
      OFS_CONTROL: rdata_o = {2'h0, device_control};
      OFS_FIFO: rdata_o = (mode == MODE_CONFIG) ? CFG_A_VALUE : (f_out_valid ? f_out.data : last_rd);
      OFS_CFG_B: rdata_o = (mode == MODE_CONFIG) ? {1'b0, irq_level_i, 6'h00} : 8'h00;
      OFS_EXT_CTRL: rdata_o = {mode, err, dma_en, svc, (f_count == 5'(FIFO_DEPTH)), ~f_out_valid};
      default: rdata_o = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  always_comb begin
    host_clock_line_n_o = ~device_control[CTL_STROBE];
    host_handshake_line_n_o = ~device_control[CTL_AUTOFD];
    init_line_n_o = device_control[CTL_INIT];
    mode_select_line_n_o = ~device_control[CTL_SELIN];
    pdata_o = port_data;
    pdata_oe_o = ~dir_in;
    if (is_ecp | is_compat_data_fifo) begin
      host_clock_line_n_o = ~(state == LS_FSTB);
      host_handshake_line_n_o = is_ecp ? (rev_dir ? (state != LS_RREQ) : ~out_word.tag) : 1'b1;
      init_line_n_o = is_ecp ? ~rev_dir : device_control[CTL_INIT];
      mode_select_line_n_o = is_ecp ? 1'b1 : ~device_control[CTL_SELIN];
      pdata_o = out_word.data;
      pdata_oe_o = is_compat_data_fifo | (~rev_dir & (state != LS_TURN) & direction_acknowledge_n_i);
    end
  end
  assign error_o = err;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_data <= DATA_RESET;
      device_control <= CTRL_RESET;
      mode <= EXT_MODE_RESET;
      dma_en <= 1'b0;
      svc <= 1'b0;
      err <= 1'b0;
      last_rd <= 8'h00;
      rle_cnt <= 8'h00;
      rle_pend <= 1'b0;
      state <= LS_IDLE;
      out_word <= '0;
      rev_dir <= 1'b0;
    end else begin
      port_data <= next_port_data;
      device_control <= next_device_control;
      mode <= next_mode;
      dma_en <= next_dma_en;
      svc <= next_svc;
      err <= next_err;
      last_rd <= next_last_rd;
      rle_cnt <= next_rle_cnt;
      rle_pend <= next_rle_pend;
      state <= next_state;
      out_word <= next_out_word;
      rev_dir <= next_rev_dir;
    end
  end
endmodule // ecp_port

// >>> bench/ecp_port_monitor.sv
`timescale 1ns/1ps
module ecp_port_monitor import ecp_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [10:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  // cable
  input wire logic host_clock_line_n_o,
  input wire logic host_handshake_line_n_o,
  input wire logic init_line_n_o,
  input wire logic mode_select_line_n_o,
  input wire logic pdata_oe_o,
  input wire logic periph_handshake_i,
  input wire logic direction_acknowledge_n_i,
  input wire logic fault_line_n_i,
  input wire logic error_o
);
  // ---------------------------------------------------------------
  // shadow of mode and control, taken from the write strobes
  // ---------------------------------------------------------------
  logic [2:0] mode, next_mode;
  logic [5:0] ctrl, next_ctrl;
  logic fifo_md;
  always_comb begin
    next_mode = mode;
    next_ctrl = ctrl;
    if (wr_i && addr_i == OFS_EXT_CTRL) next_mode = wdata_i[7:5];
    if (wr_i && addr_i == OFS_CONTROL) next_ctrl = wdata_i[5:0];
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode <= 3'h0;
      ctrl <= 6'h00;
    end else begin
      mode <= next_mode;
      ctrl <= next_ctrl;
    end
  end
  assign fifo_md = (mode == MODE_COMPAT_DATA_FIFO) || (mode == MODE_ECP);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  strobe_cause_a: assert property (fifo_md && $fell(host_clock_line_n_o) |-> $past(!periph_handshake_i))
    else $error("strobe started while peripheral busy");
  strobe_hold_a: assert property (fifo_md && !host_clock_line_n_o && !periph_handshake_i |=> !host_clock_line_n_o)
    else $error("strobe released before busy");
  strobe_end_a: assert property (fifo_md && !host_clock_line_n_o && periph_handshake_i |-> ##[1:3] host_clock_line_n_o)
    else $error("strobe stuck after busy");
  oe_turn_a: assert property (mode == MODE_ECP && $rose(pdata_oe_o) |-> direction_acknowledge_n_i)
    else $error("bus driven before forward acknowledge");
  mode_sel_a: assert property (mode == MODE_ECP |-> mode_select_line_n_o)
    else $error("mode select asserted in extended mode");
  std_pins_a: assert property (mode == MODE_STD |-> host_clock_line_n_o == !ctrl[CTL_STROBE]
    && init_line_n_o == ctrl[CTL_INIT] && host_handshake_line_n_o == !ctrl[CTL_AUTOFD]
    && mode_select_line_n_o == !ctrl[CTL_SELIN]) else $error("control pins differ from register");
  fixed_dir_a: assert property (mode == MODE_STD || mode == MODE_COMPAT_DATA_FIFO |-> pdata_oe_o)
    else $error("bus released in output only mode");
  cfga_value_a: assert property (mode == MODE_CONFIG && addr_i == OFS_FIFO |-> rdata_o == 8'h10)
    else $error("configuration a value wrong");
  error_set_a: assert property (mode == MODE_ECP && !ctrl[CTL_DIR] && !fault_line_n_i [*2] |-> ##[0:2] error_o)
    else $error("fault did not raise error");
endmodule // ecp_port_monitor

bind ecp_port ecp_port_monitor u_mon (.clk_i, .resetn_i, .addr_i, .wr_i, .wdata_i, .rdata_o,
  .host_clock_line_n_o, .host_handshake_line_n_o, .init_line_n_o, .mode_select_line_n_o, .pdata_oe_o,
  .periph_handshake_i, .direction_acknowledge_n_i, .fault_line_n_i, .error_o);

// >>> bench/ecp_peer.sv
`timescale 1ns/1ps
module ecp_peer (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // host side of cable
  input wire logic host_clock_line_n_i,
  input wire logic host_handshake_line_n_i,
  input wire logic init_line_n_i,
  input wire logic [7:0] pdata_i,
  // peripheral drive
  output logic [7:0] pdata_o,
  output logic periph_clock_line_n_o,
  output logic periph_handshake_o,
  output logic direction_acknowledge_n_o
);
  logic [8:0] rev_q[$];
  logic [8:0] fwd_q[$];
  logic [7:0] dat;
  logic stall;
  logic drv;
  initial stall = 1'b0;
  // released bus shows the inverse of the last byte, never a held value
  assign pdata_o = (drv && !host_handshake_line_n_i && !direction_acknowledge_n_o) ? dat : ~dat;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      periph_handshake_o <= 1'b0;
      periph_clock_line_n_o <= 1'b1;
      direction_acknowledge_n_o <= 1'b1;
      drv <= 1'b0;
      dat <= 8'h00;
    end else begin
      direction_acknowledge_n_o <= init_line_n_i;
      if (direction_acknowledge_n_o) begin
        periph_handshake_o <= stall | !host_clock_line_n_i;
        if (!host_clock_line_n_i && !periph_handshake_o) fwd_q.push_back({host_handshake_line_n_i, pdata_i});
      end else if (!host_handshake_line_n_i && periph_clock_line_n_o) begin
        if (drv) begin
          periph_clock_line_n_o <= 1'b0;
        end else if (rev_q.size() > 0) begin
          dat <= rev_q[0][7:0];
          periph_handshake_o <= !rev_q[0][8];
          drv <= 1'b1;
        end
      end else if (host_handshake_line_n_i && !periph_clock_line_n_o) begin
        periph_clock_line_n_o <= 1'b1;
        drv <= 1'b0;
        void'(rev_q.pop_front());
      end
    end
  end
endmodule // ecp_peer

// >>> bench/tb_ecp_parallel_port_isa.sv
`timescale 1ns/1ps
module tb_ecp_parallel_port_isa;
  import ecp_pkg::*;
  logic clk_i, resetn_i, we, re, flt_n, oe, hclk_n, hshk_n, ini_n, msel_n, pclk_n, busy, dack_n, dreq, err;
  logic dma_ack;
  logic [10:0] addr;
  logic [7:0] wd, rdat, pdh, pdp, bus, v;
  int bad_count = 0;
  int checked = 0;
  assign bus = oe ? pdh : pdp;
  ecp_port dut (.clk_i, .resetn_i, .addr_i(addr), .wr_i(we), .rd_i(re), .wdata_i(wd), .rdata_o(rdat),
    .dma_req_o(dreq), .dma_ack_i(dma_ack), .host_clock_line_n_o(hclk_n), .host_handshake_line_n_o(hshk_n),
    .init_line_n_o(ini_n), .mode_select_line_n_o(msel_n), .pdata_i(bus), .pdata_o(pdh), .pdata_oe_o(oe),
    .periph_clock_line_n_i(pclk_n), .periph_handshake_i(busy), .direction_acknowledge_n_i(dack_n),
    .fault_line_n_i(flt_n), .select_i(1'b1), .irq_level_i(1'b1), .error_o(err));
  ecp_peer peer (.clk_i, .resetn_i, .host_clock_line_n_i(hclk_n), .host_handshake_line_n_i(hshk_n),
    .init_line_n_i(ini_n), .pdata_i(bus), .pdata_o(pdp), .periph_clock_line_n_o(pclk_n),
    .periph_handshake_o(busy), .direction_acknowledge_n_o(dack_n));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [10:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
    // let the write land before any pin or flag is looked at
    @(negedge clk_i);
  endtask
  task automatic rdr(logic [10:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    d = rdat;
    re <= 1'b0;
  endtask
  task automatic wait_fwd(int n);
    for (int i = 0; i < 500 && peer.fwd_q.size() < n; i++) @(posedge clk_i);
    chk("fwd count", 8'(n), 8'(peer.fwd_q.size()));
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rdr(OFS_CONTROL, v);
    chk("ctrl reset", 8'h00, v);
    rdr(OFS_EXT_CTRL, v);
    chk("ecr reset", 8'h01, v & 8'hfb);
    wr(11'h003, 8'hff);
    rdr(OFS_DATA, v);
    chk("data after unmapped", 8'h00, v);
    for (int m = 0; m < 8; m++) begin
      wr(OFS_EXT_CTRL, 8'(m << 5));
      rdr(OFS_EXT_CTRL, v);
      chk("mode", 8'(m), 8'(v[7:5]));
    end
    rdr(OFS_FIFO, v);
    chk("cfga", 8'h10, v);
    rdr(OFS_CFG_B, v);
    chk("cfgb", 8'h40, v & 8'hc0);
    wr(OFS_EXT_CTRL, 8'h00);
  endtask
  task automatic t_std;
    wr(OFS_CONTROL, 8'h2f);
    wr(OFS_DATA, 8'h5a);
    chk("pins", 8'h12, {3'h0, oe, hclk_n, hshk_n, ini_n, msel_n});
    chk("pdata", 8'h5a, pdh);
    wr(OFS_CONTROL, 8'h24);
    wr(OFS_EXT_CTRL, 8'h20);
    chk("oe bidir in", 8'h00, 8'(oe));
    wr(OFS_EXT_CTRL, 8'h40);
    chk("oe compat_data_fifo", 8'h01, 8'(oe));
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_EXT_CTRL, 8'h00);
  endtask
  task automatic t_compat_data_fifo;
    peer.stall <= 1'b1;
    peer.fwd_q.delete();
    wr(OFS_EXT_CTRL, 8'h48);
    chk("dma req", 8'h01, 8'(dreq));
    for (int i = 0; i < 17; i++) wr(OFS_FIFO, 8'(8'h30 + i));
    rdr(OFS_EXT_CTRL, v);
    chk("full", 8'h02, v & 8'h03);
    chk("held while busy", 8'h00, 8'(peer.fwd_q.size()));
    peer.stall <= 1'b0;
    wait_fwd(16);
    for (int i = 0; i < 16; i++) chk("compat_data_fifo byte", 8'(8'h30 + i), peer.fwd_q[i][7:0]);
    rdr(OFS_EXT_CTRL, v);
    chk("empty", 8'h01, v & 8'h03);
  endtask
  task automatic t_efwd;
    peer.fwd_q.delete();
    wr(OFS_EXT_CTRL, 8'h68);
    wr(OFS_DATA, 8'h05);
    wr(OFS_FIFO, 8'ha7);
    wait_fwd(2);
    chk("addr byte", 8'h05, peer.fwd_q[0][7:0]);
    chk("addr tag", 8'h00, 8'(peer.fwd_q[0][8]));
    chk("data byte", 8'ha7, peer.fwd_q[1][7:0]);
    chk("data tag", 8'h01, 8'(peer.fwd_q[1][8]));
    chk("ecp dma req", 8'h01, 8'(dreq));
    @(posedge clk_i);
    wd <= 8'h3c;
    dma_ack <= 1'b1;
    @(posedge clk_i);
    dma_ack <= 1'b0;
    wait_fwd(3);
    chk("dma byte", 8'h3c, peer.fwd_q[2][7:0]);
    chk("dma tag", 8'h01, 8'(peer.fwd_q[2][8]));
  endtask
  task automatic t_err;
    flt_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("error", 8'h01, 8'(err));
    chk("dir kept", 8'h03, {6'h0, ini_n, oe});
    rdr(OFS_STATUS, v);
    chk("status", 8'h10, v & 8'h1f);
    flt_n <= 1'b1;
    wr(OFS_EXT_CTRL, 8'h60);
    chk("error clear", 8'h00, 8'(err));
  endtask
  task automatic t_rev;
    peer.rev_q = '{9'h102, 9'h0ab};
    for (int i = 0; i < 15; i++) peer.rev_q.push_back(9'(8'h50 + i));
    wr(OFS_CONTROL, 8'h20);
    repeat (200) @(posedge clk_i);
    chk("reverse pins", 8'h00, {6'h0, ini_n, oe});
    chk("paused", 8'h01, 8'(peer.rev_q.size() > 0));
    rdr(OFS_EXT_CTRL, v);
    chk("rev full", 8'h02, v & 8'h03);
    for (int i = 0; i < 18; i++) begin
      rdr(OFS_FIFO, v);
      chk("rev byte", (i < 3) ? 8'hab : 8'(8'h4d + i), v);
    end
    rdr(OFS_EXT_CTRL, v);
    chk("rev empty", 8'h01, v & 8'h03);
    wr(OFS_CONTROL, 8'h04);
    repeat (10) @(posedge clk_i);
    chk("forward again", 8'h03, {6'h0, ini_n, oe});
  endtask
  // ---------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    resetn_i = 1'b0;
    we = 1'b0;
    re = 1'b0;
    addr = 11'h000;
    wd = 8'h00;
    flt_n = 1'b1;
    dma_ack = 1'b0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_std();
    t_compat_data_fifo();
    t_efwd();
    t_err();
    t_rev();
    conclude();
  end
  // whole run needs several hundred cycles; the 30000-cycle limit is far beyond that, so reaching it means a hang
  initial begin
    #300000;
    bad_count++;
    conclude();
  end
endmodule // tb_ecp_parallel_port_isa
